/* File: hdl/sram_rd_pkg.sv */
package sram_rd_pkg;

  // ==========================================================================
  // Organisation
  // Width pair of the narrow and of the wide part; the narrow one is built.
  localparam int DATA_W_NARROW = 18;
  localparam int ADDR_W_NARROW = 20;
  localparam int DATA_W_WIDE   = 36;
  localparam int ADDR_W_WIDE   = 19;
  localparam bit USE_WIDE      = 1'b0;
  localparam int DATA_W        = USE_WIDE ? DATA_W_WIDE : DATA_W_NARROW;
  localparam int ADDR_W        = USE_WIDE ? ADDR_W_WIDE : ADDR_W_NARROW;

  // Four arrays, one per beat, each as deep as the burst address space.
  localparam int BANK_CNT   = 4;
  localparam int BANK_DEPTH = 1 << ADDR_W;

  // ==========================================================================
  // Burst and latency
  localparam int BEAT_W         = 2;
  localparam int BURST_LEN      = 4;
  localparam logic [1:0] LAST_BEAT  = 2'h3;
  localparam logic [1:0] FIRST_BEAT = 2'h0;
  // Read latency of two and a half input clock cycles, counted in
  // input clock edges of either polarity.
  localparam int RD_LAT_EDGES = 5;
  localparam int PIPE_DEPTH   = RD_LAT_EDGES;

  // ==========================================================================
  // Types
  typedef logic [DATA_W-1:0] word_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [BEAT_W-1:0] beat_t;

  typedef enum logic [1:0] {
    OUT_IDLE,
    OUT_BEAT,
    OUT_TAIL
  } out_state_t;

endpackage

/* File: hdl/burst_array_if.sv */
interface burst_array_if;

  // Write side.
  logic                wrEn;
  sram_rd_pkg::beat_t  wrBank;
  sram_rd_pkg::addr_t  wrAddr;
  sram_rd_pkg::word_t  wrData;

  // Read side.
  sram_rd_pkg::beat_t  rdBank;
  sram_rd_pkg::addr_t  rdAddr;
  sram_rd_pkg::word_t  rdData;

  modport ctrl (
    output wrEn,
    output wrBank,
    output wrAddr,
    output wrData,
    output rdBank,
    output rdAddr,
    input  rdData
  );

  modport mem (
    input  wrEn,
    input  wrBank,
    input  wrAddr,
    input  wrData,
    input  rdBank,
    input  rdAddr,
    output rdData
  );

endinterface

/* File: hdl/burst_array.sv */
module burst_array (
  // Clock.
  input wire logic     core_clk,
  // Array access.
  burst_array_if.mem   arr
);

  sram_rd_pkg::word_t bankOut [sram_rd_pkg::BANK_CNT];

  // ==========================================================================
  // Banks
  // One bank per beat position, so a burst address picks the same row in
  // all four banks and the beat number picks the bank.
  genvar b;
  generate
    for (b = 0; b < sram_rd_pkg::BANK_CNT; b++) begin : g_bank
      sram_rd_pkg::word_t store [sram_rd_pkg::BANK_DEPTH];

      // Writes land on the same clock edge that carries the beat.
      always_ff @(posedge core_clk) begin
        if (arr.wrEn && arr.wrBank == sram_rd_pkg::beat_t'(b)) begin
          store[arr.wrAddr] <= arr.wrData;
        end
      end

      // Read is combinational; the caller registers the result.
      assign bankOut[b] = store[arr.rdAddr];
    end
  endgenerate

  assign arr.rdData = bankOut[arr.rdBank];

endmodule

/* File: hdl/burst_sram_read_port.sv */
module burst_sram_read_port (
  // Clock and reset.
  input  wire logic                core_clk,
  input  wire logic                reset,
  // Input clock pair, sampled as levels.
  input  wire logic                kClk,
  input  wire logic                kClkN,
  // Requests.
  input  wire sram_rd_pkg::addr_t  address,
  input  wire logic                readPortSelectN,
  input  wire logic                writePortSelectN,
  input  wire sram_rd_pkg::word_t  writeData,
  // Read data pins and valid indicator.
  output      sram_rd_pkg::word_t  readData,
  output      logic                readDataOe,
  output      logic                readValidFlag
);

  // ==========================================================================
  // Declarations
  logic                     kPrev_reg;
  logic                     kNPrev_reg;
  logic                     kRise;
  logic                     kNRise;
  logic                     anyEdge;
  logic                     rdBusy_reg;
  logic                     rdAccept;
  logic                     pendV_reg [sram_rd_pkg::PIPE_DEPTH];
  sram_rd_pkg::addr_t       pendA_reg [sram_rd_pkg::PIPE_DEPTH];
  logic                     burstStart;
  sram_rd_pkg::out_state_t  state_reg;
  sram_rd_pkg::beat_t       beat_reg;
  sram_rd_pkg::addr_t       burstA_reg;
  sram_rd_pkg::word_t       readData_reg;
  logic                     readDataOe_reg;
  logic                     readValid_reg;
  logic                     wrBusy_reg;
  logic                     wrAccept;
  logic                     wrActive_reg;
  sram_rd_pkg::beat_t       wrBeat_reg;
  sram_rd_pkg::addr_t       wrAddr_reg;
  burst_array_if            arr ();

  localparam int LAST = sram_rd_pkg::PIPE_DEPTH - 1;

  // True on the final beat of a four-beat burst, read or write.
  function automatic logic isLastBeat(input sram_rd_pkg::beat_t beat);
    isLastBeat = (beat == sram_rd_pkg::LAST_BEAT);
  endfunction

  // ==========================================================================
  // Input clock edges
  // Both input clocks are slower than core_clk, so a rise is seen as a
  // level that was low on the previous core_clk edge and is high now.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      kPrev_reg  <= 1'b1;
      kNPrev_reg <= 1'b1;
    end else begin
      kPrev_reg  <= kClk;
      kNPrev_reg <= kClkN;
    end
  end

  assign kRise   = kClk & ~kPrev_reg;
  assign kNRise  = kClkN & ~kNPrev_reg;
  assign anyEdge = kRise | kNRise;

  // ==========================================================================
  // Read request capture
  // A read occupies the read port for two input clock cycles, so a read
  // select on the primary rise just after an accepted one is not taken.
  assign rdAccept = kRise & ~readPortSelectN & ~rdBusy_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdBusy_reg <= 1'b0;
    end else if (kRise) begin
      rdBusy_reg <= rdAccept;
    end
  end

  // ==========================================================================
  // Latency pipeline
  // Stage zero takes the address with the request; every later edge of
  // either clock moves it one stage, giving two and a half cycles.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pendV_reg[0] <= 1'b0;
      pendA_reg[0] <= '0;
    end else if (anyEdge) begin
      pendV_reg[0] <= rdAccept;
      if (rdAccept) begin
        pendA_reg[0] <= address;
      end
    end
  end

  genvar s;
  generate
    for (s = 1; s < sram_rd_pkg::PIPE_DEPTH; s++) begin : g_pipe
      always_ff @(posedge core_clk) begin
        if (reset) begin
          pendV_reg[s] <= 1'b0;
          pendA_reg[s] <= '0;
        end else if (anyEdge) begin
          pendV_reg[s] <= pendV_reg[s-1];
          pendA_reg[s] <= pendA_reg[s-1];
        end
      end
    end
  endgenerate

  // The next edge after the last stage launches beat zero.
  assign burstStart = anyEdge & pendV_reg[LAST];

  // ==========================================================================
  // Array hookup
  // The first beat reads straight from the pipeline so it leaves on the
  // launching edge; later beats use the address held for the burst.
  assign arr.rdBank = burstStart ? sram_rd_pkg::FIRST_BEAT : beat_reg;
  assign arr.rdAddr = burstStart ? pendA_reg[LAST] : burstA_reg;
  assign arr.wrEn   = anyEdge & wrActive_reg;
  assign arr.wrBank = wrBeat_reg;
  assign arr.wrAddr = wrAddr_reg;
  assign arr.wrData = writeData;

  burst_array u_array (
    .core_clk (core_clk),
    .arr      (arr.mem)
  );

  // ==========================================================================
  // Read burst sequencer
  // A new burst always wins over the tail of the previous one, which lets
  // bursts spaced two cycles apart run with no gap on the pins.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg  <= sram_rd_pkg::OUT_IDLE;
      beat_reg   <= sram_rd_pkg::FIRST_BEAT;
      burstA_reg <= '0;
    end else if (burstStart) begin
      state_reg  <= sram_rd_pkg::OUT_BEAT;
      beat_reg   <= sram_rd_pkg::beat_t'(1);
      burstA_reg <= pendA_reg[LAST];
    end else if (anyEdge) begin
      unique case (state_reg)
        sram_rd_pkg::OUT_BEAT: begin
          if (isLastBeat(beat_reg)) begin
            state_reg <= sram_rd_pkg::OUT_TAIL;
          end
          beat_reg <= beat_reg + sram_rd_pkg::beat_t'(1);
        end
        sram_rd_pkg::OUT_TAIL: begin
          if (kRise) begin
            state_reg <= sram_rd_pkg::OUT_IDLE;
          end
        end
        sram_rd_pkg::OUT_IDLE: begin
          state_reg <= sram_rd_pkg::OUT_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Read data and valid flag
  // Data and valid share one register update, so the flag moves on the
  // same edge as the data it qualifies.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      readData_reg  <= '0;
      readValid_reg <= 1'b0;
    end else if (anyEdge) begin
      if (burstStart || state_reg == sram_rd_pkg::OUT_BEAT) begin
        readData_reg  <= arr.rdData;
        readValid_reg <= 1'b1;
      end else begin
        readValid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Output enable
  // After the last beat the pins keep driving the last word until the
  // next primary rise; only then do they float.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      readDataOe_reg <= 1'b0;
    end else if (burstStart) begin
      readDataOe_reg <= 1'b1;
    end else if (kRise && state_reg == sram_rd_pkg::OUT_TAIL) begin
      readDataOe_reg <= 1'b0;
    end
  end

  assign readData      = readData_reg;
  assign readDataOe    = readDataOe_reg;
  assign readValidFlag = readValid_reg;

  // ==========================================================================
  // Write port
  // Writes share the address bus; beats arrive on the four edges after the
  // select. A write select on the rise after an accepted one is not taken.
  assign wrAccept = kRise & ~writePortSelectN & ~wrBusy_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrBusy_reg <= 1'b0;
    end else if (kRise) begin
      wrBusy_reg <= wrAccept;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrActive_reg <= 1'b0;
      wrBeat_reg   <= sram_rd_pkg::FIRST_BEAT;
      wrAddr_reg   <= '0;
    end else if (wrAccept) begin
      wrActive_reg <= 1'b1;
      wrBeat_reg   <= sram_rd_pkg::FIRST_BEAT;
      wrAddr_reg   <= address;
    end else if (anyEdge && wrActive_reg) begin
      wrBeat_reg <= wrBeat_reg + sram_rd_pkg::beat_t'(1);
      if (isLastBeat(wrBeat_reg)) begin
        wrActive_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Checks
  // Helper counters that only the checks read.
  logic [3:0] edgesSinceRd_reg;
  logic [3:0] beatsRun_reg;
  logic [1:0] risesSinceRd_reg;
  logic       beatNow;

  assign beatNow = burstStart | (anyEdge & state_reg == sram_rd_pkg::OUT_BEAT);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      edgesSinceRd_reg <= 4'hf;
    end else if (rdAccept && edgesSinceRd_reg >= 4'h5) begin
      // A read accepted before the previous first beat left joins that burst
      // with no new rise of the flag, so it must not restart the count.
      edgesSinceRd_reg <= 4'h0;
    end else if (anyEdge && edgesSinceRd_reg != 4'hf) begin
      edgesSinceRd_reg <= edgesSinceRd_reg + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      beatsRun_reg <= 4'h0;
    end else if (beatNow) begin
      beatsRun_reg <= beatsRun_reg + 4'h1;
    end else if (!readValid_reg) begin
      beatsRun_reg <= 4'h0;
    end
  end

  // Primary rises since the last accepted read, saturating at three.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      risesSinceRd_reg <= 2'h3;
    end else if (rdAccept) begin
      risesSinceRd_reg <= 2'h0;
    end else if (kRise && risesSinceRd_reg != 2'h3) begin
      risesSinceRd_reg <= risesSinceRd_reg + 2'h1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_rd_accept_addr: assert property (rdAccept |=> pendV_reg[0] && pendA_reg[0] == $past(address))
    else $error("Read address not captured on accepted request.");
  a_desel_no_access: assert property (kRise && readPortSelectN |=> !pendV_reg[0])
    else $error("Deselected read edge started an access.");
  a_rd_busy_skip: assert property (rdAccept |-> risesSinceRd_reg != 2'h0)
    else $error("Read accepted on two successive primary rises.");
  a_first_beat_lat: assert property ($rose(readValidFlag) |-> edgesSinceRd_reg == 4'h5)
    else $error("First read beat not five edges after request.");
  a_burst_four: assert property ($fell(readValidFlag) |-> beatsRun_reg[1:0] == 2'h0)
    else $error("Read burst length not a multiple of four.");
  a_valid_needs_oe: assert property (readValidFlag |-> readDataOe)
    else $error("Valid flag high while outputs float.");
  a_valid_on_edge: assert property ($changed(readValidFlag) |-> $past(anyEdge))
    else $error("Valid flag changed away from an input clock edge.");
  a_beat_each_edge: assert property (beatNow |=> readValidFlag && readDataOe)
    else $error("Burst beat not driven on an input clock edge.");
  a_float_after_k: assert property ($fell(readDataOe) |-> $past(kRise) && !readValidFlag)
    else $error("Outputs floated off a primary rise or mid burst.");
  a_wr_desel: assert property (kRise && writePortSelectN && !wrActive_reg |=> !wrActive_reg)
    else $error("Deselected write edge started a write.");

  c_single_read: cover property ($rose(readValidFlag) ##[1:200] $fell(readDataOe));
  c_back_to_back: cover property (burstStart && state_reg == sram_rd_pkg::OUT_TAIL);
  c_write_then_read: cover property (wrAccept ##[1:50] rdAccept);
  c_read_and_write: cover property (rdAccept && wrAccept);

endmodule

/* File: dv/mem_ctrl_model.sv */
// ============================================================
// Controller model: input clock pair and request driver
module mem_ctrl_model (
  // Clock.
  input  wire logic                core_clk,
  // Device inputs.
  output      logic                kClk,
  output      logic                kClkN,
  output      sram_rd_pkg::addr_t  address,
  output      logic                readPortSelectN,
  output      logic                writePortSelectN,
  output      sram_rd_pkg::word_t  writeData
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] phaseReg  = 2'h0;
  logic       lostPhase = 1'b0;

  // Idle levels at time zero: both ports deselected.
  initial begin
    address          = '0;
    readPortSelectN  = 1'b1;
    writePortSelectN = 1'b1;
    writeData        = '0;
  end

  // The pair runs free at a quarter of core_clk, so each phase spans two samples.
  always @(posedge core_clk) begin
    phaseReg <= phaseReg + 2'h1;
    kClk     <= ~phaseReg[1];
    kClkN    <= phaseReg[1];
  end

  // Launches one request on the edge before a primary rise, skipping gap-1 of them.
  task automatic access(input logic rd, input logic wr, input logic dat, input int gap,
                        input sram_rd_pkg::addr_t a, input sram_rd_pkg::word_t d[4]);
    int seen;
    seen = 0;
    for (int i = 0; i < 4 * gap + 4 && seen < gap; i++) begin
      @(posedge core_clk);
      if (phaseReg == 2'h0) seen++;
    end
    if (seen < gap) lostPhase = 1'b1;
    readPortSelectN  <= ~rd;
    writePortSelectN <= ~wr;
    address          <= a;
    @(posedge core_clk);
    readPortSelectN  <= 1'b1;
    writePortSelectN <= 1'b1;
    address          <= ~a; // A released bus must not keep showing the old value.
    // Each beat is set up one sample ahead of the input edge that takes it.
    for (int k = 0; k < 4 && dat; k++) begin
      @(posedge core_clk);
      writeData <= d[k];
      @(posedge core_clk);
    end
    if (dat) writeData <= ~d[3];
  endtask
endmodule

/* File: dv/burst_sram_read_port_tb_top.sv */
// ============================================================
// Testbench top
module burst_sram_read_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                core_clk    = 1'b0;
  logic                reset       = 1'b1;
  logic                kClk;
  logic                kClkN;
  logic                readPortSelectN;
  logic                writePortSelectN;
  logic                readDataOe;
  logic                readValidFlag;
  sram_rd_pkg::addr_t  address;
  sram_rd_pkg::word_t  writeData;
  sram_rd_pkg::word_t  readData;
  sram_rd_pkg::word_t  wa[4];
  sram_rd_pkg::word_t  wb[4];
  sram_rd_pkg::word_t  wj[4];
  sram_rd_pkg::word_t  ab[8];
  sram_rd_pkg::word_t  ba[8];
  int                  failures    = 0;
  int                  comparisons = 0;
  localparam sram_rd_pkg::addr_t ADR_A = 20'hfffff;
  localparam sram_rd_pkg::addr_t ADR_B = 20'h00000;

  // Clock of 4 ns.
  always #2 core_clk = ~core_clk;

  mem_ctrl_model ctl (
    .core_clk         (core_clk),
    .kClk             (kClk),
    .kClkN            (kClkN),
    .address          (address),
    .readPortSelectN  (readPortSelectN),
    .writePortSelectN (writePortSelectN),
    .writeData        (writeData)
  );

  burst_sram_read_port dut (
    .core_clk         (core_clk),
    .reset            (reset),
    .kClk             (kClk),
    .kClkN            (kClkN),
    .address          (address),
    .readPortSelectN  (readPortSelectN),
    .writePortSelectN (writePortSelectN),
    .writeData        (writeData),
    .readData         (readData),
    .readDataOe       (readDataOe),
    .readValidFlag    (readValidFlag)
  );

  // ============================================================
  // Compare and report
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_word(input sram_rd_pkg::word_t got, input sram_rd_pkg::word_t exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (ctl.lostPhase !== 1'b0) failures++;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Follows n beats from the request edge; beat k is due 11+2k samples later.
  task automatic expect_burst(input int n, input sram_rd_pkg::word_t e[8]);
    repeat (10) @(posedge core_clk);
    check_bit(readValidFlag, 1'b0);
    for (int k = 0; k < n; k++) begin
      @(posedge core_clk);
      check_bit(readValidFlag, 1'b1);
      check_bit(readDataOe, 1'b1);
      check_word(readData, e[k]);
      @(posedge core_clk);
      check_bit(readValidFlag, 1'b1);
    end
    @(posedge core_clk);
    check_bit(readValidFlag, 1'b0);
    check_bit(readDataOe, n > 0);
    repeat (2) @(posedge core_clk);
    check_bit(readDataOe, 1'b0);
  endtask

  // ============================================================
  // Scenarios
  task automatic sc_reset();
    check_bit(readDataOe, 1'b0);
    check_bit(readValidFlag, 1'b0);
  endtask

  // Both address extremes are written, then one is read alone.
  task automatic sc_write_read();
    ctl.access(1'b0, 1'b1, 1'b1, 1, ADR_A, wa);
    ctl.access(1'b0, 1'b1, 1'b1, 1, ADR_B, wb);
    ctl.access(1'b1, 1'b0, 1'b0, 1, ADR_B, wa);
    expect_burst(4, ba);
  endtask

  // Reads two primary rises apart must give eight unbroken beats.
  task automatic sc_back_to_back();
    ctl.access(1'b1, 1'b0, 1'b0, 1, ADR_A, wa);
    fork
      ctl.access(1'b1, 1'b0, 1'b0, 2, ADR_B, wa);
      expect_burst(8, ab);
    join
  endtask

  // A read on the very next primary rise is dropped, so only four beats come.
  task automatic sc_refused();
    ctl.access(1'b1, 1'b0, 1'b0, 1, ADR_A, wa);
    fork
      ctl.access(1'b1, 1'b0, 1'b0, 1, ADR_B, wa);
      expect_burst(4, ab);
    join
  endtask

  // Deselected ports with data toggling start nothing and write nothing.
  task automatic sc_deselect();
    ctl.access(1'b0, 1'b0, 1'b1, 1, ADR_A, wj);
    expect_burst(0, ab);
    ctl.access(1'b1, 1'b0, 1'b0, 1, ADR_A, wa);
    expect_burst(4, ab);
  endtask

  // Hang guard for the whole run.
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    for (int k = 0; k < 4; k++) begin
      wa[k]     = sram_rd_pkg::word_t'(18'h3c3c0 + k);
      wb[k]     = sram_rd_pkg::word_t'(18'h0f0f1 * (k + 1));
      wj[k]     = ~wa[k];
      ab[k]     = wa[k];
      ab[k + 4] = wb[k];
      ba[k]     = wb[k];
      ba[k + 4] = wa[k];
    end
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    sc_reset();
    sc_write_read();
    sc_back_to_back();
    sc_refused();
    sc_deselect();
    wrap_up();
  end
endmodule
